// ### hdl/dpi_pipeline.sv
// Seven-stage execution pipeline with hardware interlock.
`timescale 1ns/10ps
// Notes on behaviour
// - Fetch segment fills a queue; this execution segment is protected.
// - Decode takes up to six queue bytes, single or paired instruction.
// - Address stage computes data addresses, pointer updates, branch addresses.
// - First access stage drives read addresses on buses b, c and d.
// - Second access stage gives memories exactly one cycle to answer.
// - Read stage captures read data and evaluates the condition.
// - Read stage drives one write address per operand write.
// - Execute stage computes and writes results into core registers.
// - Write stage sends store data to memory, I/O or mapped registers.
// - A younger instruction waits while an older one holds its location.
// - Program order kept; stalls added automatically, never reordered.
// - Conflicts are won by the instruction furthest along.
// - Local block repeat replays the queue without new fetches.
// - Sources read in read stage, destinations in execute; pointers in address.
// - Execute-stage pointer write then address-stage use stalls four cycles.
module dpi_pipeline
  import dpi_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic [DPI_QUEUE_BYTES*8-1:0] QUEUE_BYTES_IN,
  input wire logic QUEUE_VLD_IN,
  input wire logic [2:0] QUEUE_LEN_IN,
  input wire logic PAIR_IN,
  input wire logic LOCAL_RPT_IN,
  input wire logic [DPI_DATA_W-1:0] RPT_COUNT_IN,
  input wire logic [DPI_DATA_W-1:0] READ_DATA_B_IN,
  input wire logic [DPI_DATA_W-1:0] READ_DATA_C_IN,
  input wire logic [DPI_DATA_W-1:0] READ_DATA_D_IN,
  input wire logic COND_IN,
  output logic QUEUE_TAKE_OUT,
  output logic [2:0] QUEUE_TAKE_LEN_OUT,
  output logic FETCH_HOLD_OUT,
  output logic [DPI_ADDR_W-1:0] READ_ADDR_BUS_B_OUT,
  output logic [DPI_ADDR_W-1:0] READ_ADDR_BUS_C_OUT,
  output logic [DPI_ADDR_W-1:0] READ_ADDR_BUS_D_OUT,
  output logic READ_REQ_OUT,
  output logic [DPI_ADDR_W-1:0] WRITE_ADDR_OUT,
  output logic WRITE_ADDR_VLD_OUT,
  output logic [DPI_DATA_W-1:0] WRITE_DATA_OUT,
  output logic [1:0] WRITE_DEST_OUT,
  output logic WRITE_VLD_OUT,
  output logic [DPI_ADDR_W-1:0] BRANCH_ADDR_OUT,
  output logic BRANCH_VLD_OUT,
  output logic STALL_OUT,
  output logic [DPI_DATA_W-1:0] BLOCK_REPEAT_COUNTER_OUT
);
  // Decoded fields of the queue bytes: byte0 ctl, bytes1-2 srcs, byte3 dst, bytes4-5 imm
  typedef struct packed {
    logic vld;
    logic pair;
    logic [DPI_REG_W-1:0] src_a;
    logic src_a_vld;
    logic [DPI_REG_W-1:0] src_b;
    logic [DPI_REG_W-1:0] dst;
    logic dst_vld;
    logic ptr_ind;
    logic branch;
    logic wr_mem;
    logic [1:0] dest;
    logic [DPI_ADDR_W-1:0] addr;
    logic [DPI_DATA_W-1:0] data;
    logic cond_ok;
  } dpi_insn_t;

  typedef enum logic [1:0] {DPI_RUN, DPI_HOLD} dpi_mode_t;

  typedef struct packed {
    dpi_insn_t d;
    dpi_insn_t ad;
    dpi_insn_t acc_one;
    dpi_insn_t acc_two;
    dpi_insn_t rd;
    dpi_insn_t ex;
    dpi_insn_t wr;
    dpi_mode_t mode;
    logic [2:0] hold_cnt;
    logic [DPI_ADDR_W-1:0] ptr;
    logic [DPI_DATA_W-1:0] rpt_cnt;
    logic [DPI_DATA_W-1:0] result;
    logic take;
    logic [2:0] take_len;
    logic fetch_hold;
    logic rd_req;
    logic wa_vld;
    logic br_vld;
    logic stall;
    logic [DPI_ADDR_W-1:0] addr_c;
    logic [DPI_ADDR_W-1:0] addr_d;
    logic wr_vld;
  } dpi_state_t;

  dpi_state_t st_r;
  dpi_state_t st_nxt;
  logic hazard;
  logic [DPI_PEND_DEPTH-1:0][DPI_REG_W-1:0] pend_dst;
  logic [DPI_PEND_DEPTH-1:0] pend_vld;

  //////////////////////////////////////////////////////////////////////////////
  // Pending destinations are the stages from first access through execute
  assign pend_dst = {st_r.ex.dst, st_r.rd.dst, st_r.acc_two.dst, st_r.acc_one.dst};
  assign pend_vld = {st_r.ex.vld && st_r.ex.dst_vld, st_r.rd.vld && st_r.rd.dst_vld,
                     st_r.acc_two.vld && st_r.acc_two.dst_vld,
                     st_r.acc_one.vld && st_r.acc_one.dst_vld};

  dpi_interlock #(
    .DEPTH(DPI_PEND_DEPTH)
  ) u_lock (
    .src_a_in(st_r.ad.src_a),
    .src_a_vld_in(st_r.ad.vld && st_r.ad.src_a_vld),
    .src_b_in(st_r.ad.src_b),
    .src_b_vld_in(st_r.ad.vld && st_r.ad.ptr_ind),
    .pend_dst_in(pend_dst),
    .pend_vld_in(pend_vld),
    .hazard_out(hazard)
  );

  //////////////////////////////////////////////////////////////////////////////
  function automatic dpi_insn_t decode(input logic [DPI_QUEUE_BYTES*8-1:0] q,
                                       input logic pr);
    dpi_insn_t i;
    i = '0;
    i.vld = 1'b1;
    i.pair = pr;
    i.src_a_vld = q[0];
    i.dst_vld = q[1];
    i.ptr_ind = q[2];
    i.branch = q[3];
    i.wr_mem = q[4];
    i.dest = q[6:5];
    i.src_a = q[12:8];
    i.src_b = q[20:16];
    i.dst = q[28:24];
    i.data = q[47:32];
    i.addr = {8'h00, q[47:32]};
    return i;
  endfunction

  always_comb
  begin
    logic adv;
    adv = 1'b0;
    st_nxt = st_r;
    // Back half always moves: the front runner never waits
    st_nxt.wr = st_r.ex;
    st_nxt.ex = st_r.rd;
    st_nxt.rd = st_r.acc_two;
    // Memories answer during the one cycle in second access
    st_nxt.acc_two = st_r.acc_one;
    // Read data and condition caught in read stage
    if (st_r.acc_two.vld)
    begin
      // A store keeps its own data; only loads take the read buses
      if (!st_r.acc_two.wr_mem)
      begin
        st_nxt.rd.data = READ_DATA_B_IN ^ READ_DATA_C_IN ^ READ_DATA_D_IN;
      end
      st_nxt.rd.cond_ok = COND_IN;
    end
    // Execute writes the core result register
    if (st_r.ex.vld && st_r.ex.cond_ok && st_r.ex.dst_vld)
    begin
      st_nxt.result = st_r.ex.data + st_r.ex.addr[DPI_DATA_W-1:0];
    end
    // Interlock holds address stage; extended for pointer use
    unique case (st_r.mode)
      DPI_RUN:
      begin
        if (hazard)
        begin
          if (st_r.ad.ptr_ind && st_r.acc_one.vld && st_r.acc_one.dst == st_r.ad.src_b)
          begin
            st_nxt.mode = DPI_HOLD;
            st_nxt.hold_cnt = 3'(DPI_AD_STALL_CYCLES - 1);
          end
        end
        else
        begin
          adv = 1'b1;
        end
      end
      DPI_HOLD:
      begin
        st_nxt.hold_cnt = st_r.hold_cnt - 3'h1;
        if (st_r.hold_cnt == 3'h1)
        begin
          st_nxt.mode = DPI_RUN;
        end
      end
    endcase
    // Bubble goes into first access, ahead of the held instruction, so order is kept
    st_nxt.stall = !adv;
    st_nxt.acc_one = '0;
    st_nxt.rd_req = 1'b0;
    st_nxt.br_vld = 1'b0;
    if (adv)
    begin
      st_nxt.acc_one = st_r.ad;
      // Address generation and pointer update
      if (st_r.ad.vld)
      begin
        st_nxt.acc_one.addr = st_r.ad.ptr_ind ? st_r.ptr : st_r.ad.addr;
        if (st_r.ad.ptr_ind)
        begin
          st_nxt.ptr = st_r.ptr + 24'h000001;
        end
        st_nxt.br_vld = st_r.ad.branch;
        if (st_r.rpt_cnt != '0 && LOCAL_RPT_IN)
        begin
          st_nxt.rpt_cnt = st_r.rpt_cnt - 16'h0001;
        end
        st_nxt.rd_req = !st_r.ad.wr_mem;
      end
      st_nxt.ad = st_r.d;
      st_nxt.d = '0;
    end
    if (!st_r.rpt_cnt[DPI_DATA_W-1] && st_r.rpt_cnt == '0 && LOCAL_RPT_IN && !st_r.d.vld)
    begin
      st_nxt.rpt_cnt = RPT_COUNT_IN;
    end
    // Decode takes up to six bytes when the slot frees
    st_nxt.take = 1'b0;
    st_nxt.take_len = 3'h0;
    if ((adv || !st_r.d.vld) && QUEUE_VLD_IN)
    begin
      st_nxt.d = decode(QUEUE_BYTES_IN, PAIR_IN);
      st_nxt.take = 1'b1;
      st_nxt.take_len = (QUEUE_LEN_IN > 3'(DPI_QUEUE_BYTES)) ? 3'(DPI_QUEUE_BYTES)
                                                          : QUEUE_LEN_IN;
    end
    // Local repeat replays the queue, so fetches are held off
    st_nxt.fetch_hold = LOCAL_RPT_IN && (st_nxt.rpt_cnt != '0);
    // Write address issued from read stage
    st_nxt.wa_vld = st_r.acc_two.vld && st_r.acc_two.wr_mem;
    // Side bus addresses and store strobe registered so outputs leave flops
    st_nxt.addr_c = st_nxt.acc_one.addr + 24'h000001;
    st_nxt.addr_d = st_nxt.acc_one.addr + 24'h000002;
    st_nxt.wr_vld = st_r.ex.vld && st_r.ex.wr_mem && st_r.ex.cond_ok;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read addresses leave in first access
  assign READ_ADDR_BUS_B_OUT = st_r.acc_one.addr;
  assign READ_ADDR_BUS_C_OUT = st_r.addr_c;
  assign READ_ADDR_BUS_D_OUT = st_r.addr_d;
  assign READ_REQ_OUT = st_r.rd_req;
  assign WRITE_ADDR_OUT = st_r.rd.addr;
  assign WRITE_ADDR_VLD_OUT = st_r.wa_vld;
  // Store leaves in write stage to memory, I/O or mapped register
  assign WRITE_DATA_OUT = st_r.wr.data;
  assign WRITE_DEST_OUT = st_r.wr.dest;
  assign WRITE_VLD_OUT = st_r.wr_vld;
  assign BRANCH_ADDR_OUT = st_r.acc_one.addr;
  assign BRANCH_VLD_OUT = st_r.br_vld;
  assign QUEUE_TAKE_OUT = st_r.take;
  assign QUEUE_TAKE_LEN_OUT = st_r.take_len;
  assign FETCH_HOLD_OUT = st_r.fetch_hold;
  assign STALL_OUT = st_r.stall;
  assign BLOCK_REPEAT_COUNTER_OUT = st_r.rpt_cnt;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_ptr_hazard;
    st_r.mode == DPI_RUN && hazard && st_r.ad.ptr_ind && st_r.acc_one.vld &&
      st_r.acc_one.dst == st_r.ad.src_b;
  endsequence

  sequence s_four_stalls;
    STALL_OUT [*4];
  endsequence

  a_ptr_stall_four: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    s_ptr_hazard |=> s_four_stalls)
    else $error("pointer hazard did not stall four cycles");
  a_hazard_holds: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    hazard |=> STALL_OUT && st_r.ad == $past(st_r.ad))
    else $error("hazard did not hold address stage");
  a_stall_bubble: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    STALL_OUT |-> !st_r.acc_one.vld)
    else $error("stall did not insert bubble");
  a_front_moves: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    STALL_OUT |-> st_r.acc_two == $past(st_r.acc_one) && st_r.ex == $past(st_r.rd) &&
      st_r.wr == $past(st_r.ex) && st_r.rd.vld == $past(st_r.acc_two.vld))
    else $error("older instruction was held");
  a_one_cycle_resp: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    st_r.acc_one.vld |=> st_r.acc_two.vld ##1 st_r.rd.vld)
    else $error("second access not exactly one cycle");
  a_store_write: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    st_r.ex.vld && st_r.ex.wr_mem && st_r.ex.cond_ok |=> WRITE_VLD_OUT)
    else $error("store not sent in write stage");
  a_write_addr: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    st_r.acc_two.vld && st_r.acc_two.wr_mem |=> WRITE_ADDR_VLD_OUT)
    else $error("write address missing in read stage");
  a_take_limit: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    QUEUE_TAKE_OUT |-> QUEUE_TAKE_LEN_OUT <= 3'(DPI_QUEUE_BYTES))
    else $error("decode took more than six bytes");
  a_rpt_no_fetch: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
    LOCAL_RPT_IN && st_nxt.rpt_cnt != '0 |=> FETCH_HOLD_OUT)
    else $error("fetch not held during local repeat");
endmodule

// ### hdl/dpi_pkg.sv
// Constants shared by the execution pipeline and its interlock.
package dpi_pkg;
  localparam int DPI_QUEUE_BYTES = 6;
  localparam int DPI_NUM_STAGES = 7;
  localparam int DPI_REG_W = 5;
  localparam int DPI_ADDR_W = 24;
  localparam int DPI_DATA_W = 16;
  localparam int DPI_PEND_DEPTH = 4;
  localparam int DPI_AD_STALL_CYCLES = 4;
  localparam int DPI_RPT_TAIL_INSNS = 4;
  localparam int DPI_MEM_RESP_CYCLES = 1;
  localparam logic [1:0] DPI_DST_MEM = 2'h0;
  localparam logic [1:0] DPI_DST_IO = 2'h1;
  localparam logic [1:0] DPI_DST_MAPPED = 2'h2;
  localparam logic [1:0] DPI_DST_NONE = 2'h3;
  localparam logic [2:0] DPI_STG_AD = 3'h1;
  localparam logic [2:0] DPI_STG_ACC_ONE = 3'h2;
  localparam logic [2:0] DPI_STG_ACC_TWO = 3'h3;
  localparam logic [2:0] DPI_STG_R = 3'h4;
  localparam logic [2:0] DPI_STG_X = 3'h5;
  localparam logic [2:0] DPI_STG_W = 3'h6;
endpackage

// ### hdl/dpi_interlock.sv
// Hazard comparator: address-stage sources against pending destinations.
`timescale 1ns/10ps
module dpi_interlock
  import dpi_pkg::*;
#(
  parameter int DEPTH = DPI_PEND_DEPTH
)
(
  input wire logic [DPI_REG_W-1:0] src_a_in,
  input wire logic src_a_vld_in,
  input wire logic [DPI_REG_W-1:0] src_b_in,
  input wire logic src_b_vld_in,
  input wire logic [DEPTH-1:0][DPI_REG_W-1:0] pend_dst_in,
  input wire logic [DEPTH-1:0] pend_vld_in,
  output logic hazard_out
);
  logic [DEPTH-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_cmp
      // Match while the older destination is still unwritten
      assign hit[g] = pend_vld_in[g] &&
        ((src_a_vld_in && (src_a_in == pend_dst_in[g])) ||
         (src_b_vld_in && (src_b_in == pend_dst_in[g])));
    end
  endgenerate
  assign hazard_out = |hit;
endmodule

// ### sim/dpi_mem_model.sv
// Data memory model that answers read requests on buses b, c and d.
`timescale 1ns/10ps
module dpi_mem_model
  import dpi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic [DPI_ADDR_W-1:0] addr_b_in,
  input wire logic [DPI_ADDR_W-1:0] addr_c_in,
  input wire logic [DPI_ADDR_W-1:0] addr_d_in,
  output logic [DPI_DATA_W-1:0] data_b_out,
  output logic [DPI_DATA_W-1:0] data_c_out,
  output logic [DPI_DATA_W-1:0] data_d_out
);
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      data_b_out <= 16'h0;
      data_c_out <= 16'h0;
      data_d_out <= 16'h0;
    end
    else if (req_in)
    begin
      // Answer lands in the one cycle after the address
      data_b_out <= addr_b_in[15:0] ^ 16'h5a5a;
      data_c_out <= addr_c_in[15:0] ^ 16'h5a5a;
      data_d_out <= addr_d_in[15:0] ^ 16'h5a5a;
    end
    else
    begin
      // Outside the answer cycle the buses toggle between the last answer and its inverse
      data_b_out <= ~data_b_out;
      data_c_out <= ~data_c_out;
      data_d_out <= ~data_d_out;
    end
  end
endmodule

// ### sim/tb.sv
// Self-checking bench for the execution pipeline and its interlock.
`timescale 1ns/10ps
module tb;
  import dpi_pkg::*;
  typedef struct {logic [7:0] b0; logic [1:0] dest; logic st; logic br; logic cd;} dpi_row_t;
  logic clk, rstn, q_vld, pair, lrpt, cond;
  logic [47:0] q_bytes;
  logic [2:0] q_len;
  logic [15:0] rcnt, db, dc, dd, cnt;
  logic take, hold, rreq, wavld, wvld, bvld, stall;
  logic [2:0] take_len, ctl;
  logic [23:0] ab, ac, ad, wa, ba, cap_b, cap_c, cap_d, cwa, cba;
  logic [15:0] wd, cwd;
  logic [1:0] wdst, cdst;
  int n_errors, total_checks, n_stall, t_tk, t_rr, t_wa, t_wv;
  logic seen_take, seen_br;
  dpi_row_t rows [6];
  ////////////////////////////////////////////////////////////////////////////
  dpi_pipeline i_dut (.CORE_CLK_IN(clk), .RESETN_IN(rstn), .QUEUE_BYTES_IN(q_bytes),
    .QUEUE_VLD_IN(q_vld), .QUEUE_LEN_IN(q_len), .PAIR_IN(pair), .LOCAL_RPT_IN(lrpt),
    .RPT_COUNT_IN(rcnt), .READ_DATA_B_IN(db), .READ_DATA_C_IN(dc), .READ_DATA_D_IN(dd),
    .COND_IN(cond), .QUEUE_TAKE_OUT(take), .QUEUE_TAKE_LEN_OUT(take_len),
    .FETCH_HOLD_OUT(hold), .READ_ADDR_BUS_B_OUT(ab), .READ_ADDR_BUS_C_OUT(ac),
    .READ_ADDR_BUS_D_OUT(ad), .READ_REQ_OUT(rreq), .WRITE_ADDR_OUT(wa),
    .WRITE_ADDR_VLD_OUT(wavld), .WRITE_DATA_OUT(wd), .WRITE_DEST_OUT(wdst),
    .WRITE_VLD_OUT(wvld), .BRANCH_ADDR_OUT(ba), .BRANCH_VLD_OUT(bvld), .STALL_OUT(stall),
    .BLOCK_REPEAT_COUNTER_OUT(cnt));
  dpi_mem_model i_mem (.clk_in(clk), .rstn_in(rstn), .req_in(rreq), .addr_b_in(ab),
    .addr_c_in(ac), .addr_d_in(ad), .data_b_out(db), .data_c_out(dc), .data_d_out(dd));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  function automatic logic [47:0] mk(logic [7:0] b0, logic [4:0] sa, logic [4:0] sb,
                                     logic [4:0] dst, logic [15:0] imm);
    return {imm, 3'h0, dst, 3'h0, sb, 3'h0, sa, b0};
  endfunction
  // Presents one or two instructions on consecutive edges once no stall is up
  task automatic send(input logic [47:0] q1, input logic [47:0] q2, input bit two);
    int k;
    k = 0;
    while (stall !== 1'b0 && k < 50)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 50)
    begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge clk);
    q_bytes <= q1;
    q_vld <= 1'b1;
    q_len <= 3'h7;
    @(posedge clk);
    q_bytes <= q2;
    q_vld <= two;
    if (two)
    begin
      @(posedge clk);
      q_vld <= 1'b0;
    end
  endtask
  task automatic observe();
    n_stall = 0;
    t_tk = -1;
    t_rr = -1;
    t_wa = -1;
    t_wv = -1;
    seen_take = 1'b0;
    seen_br = 1'b0;
    for (int i = 0; i < 30; i++)
    begin
      @(negedge clk);
      if (stall === 1'b1) n_stall++;
      if (take === 1'b1) seen_take = 1'b1;
      if (take === 1'b1 && t_tk < 0)
      begin
        t_tk = i;
        ctl = take_len;
      end
      if (bvld === 1'b1 && seen_br !== 1'b1)
      begin
        seen_br = 1'b1;
        cba = ba;
      end
      if (rreq === 1'b1 && t_rr < 0)
      begin
        t_rr = i;
        cap_b = ab;
        cap_c = ac;
        cap_d = ad;
      end
      if (wavld === 1'b1 && t_wa < 0)
      begin
        t_wa = i;
        cwa = wa;
      end
      if (wvld === 1'b1 && t_wv < 0)
      begin
        t_wv = i;
        cdst = wdst;
        cwd = wd;
      end
    end
  endtask
  task automatic chk_zero();
    chk("outs_in_reset", 32'h0, {take, rreq, wavld, wvld, bvld, stall, cnt});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    q_bytes = '0;
    q_vld = 1'b0;
    q_len = 3'h0;
    pair = 1'b0;
    lrpt = 1'b0;
    rcnt = 16'h0;
    cond = 1'b1;
    n_errors = 0;
    total_checks = 0;
    rows = '{'{8'h10, 2'h0, 1'b1, 1'b0, 1'b1}, '{8'h30, 2'h1, 1'b1, 1'b0, 1'b1},
             '{8'h50, 2'h2, 1'b1, 1'b0, 1'b1}, '{8'h60, 2'h3, 1'b0, 1'b0, 1'b1},
             '{8'h68, 2'h3, 1'b0, 1'b1, 1'b1}, '{8'h10, 2'h0, 1'b0, 1'b0, 1'b0}};
    repeat (3) @(posedge clk);
    chk_zero();
    rstn <= 1'b1;
    foreach (rows[r])
    begin
      @(posedge clk);
      cond <= rows[r].cd;
      send(mk(rows[r].b0, 5'h0, 5'h0, 5'h0, 16'h1230 + 16'(r)), '0, 1'b0);
      observe();
      chk("take", 32'h1, 32'(seen_take));
      chk("take_len", 32'(DPI_QUEUE_BYTES), 32'(ctl));
      chk("write_vld", 32'(rows[r].st), 32'(t_wv >= 0));
      chk("branch_vld", 32'(rows[r].br), 32'(seen_br));
      chk("stall_free", 32'h0, 32'(n_stall));
      if (rows[r].st)
      begin
        chk("write_dest", 32'(rows[r].dest), 32'(cdst));
        chk("write_data", 32'h1230 + 32'(r), 32'(cwd));
        chk("wv_after_take", 32'h6, 32'(t_wv - t_tk));
      end
      if (rows[r].b0[4])
      begin
        chk("write_addr", 32'h1230 + 32'(r), 32'(cwa));
        chk("wa_after_take", 32'h4, 32'(t_wa - t_tk));
      end
      else
      begin
        chk("rd_after_take", 32'h2, 32'(t_rr - t_tk));
        chk("addr_b", 32'h1230 + 32'(r), 32'(cap_b));
        chk("addr_c", 32'h1231 + 32'(r), 32'(cap_c));
        chk("addr_d", 32'h1232 + 32'(r), 32'(cap_d));
      end
      if (rows[r].br)
        chk("branch_addr", 32'h1230 + 32'(r), 32'(cba));
    end
    send(mk(8'h62, 5'h0, 5'h0, 5'h3, 16'h0), mk(8'h64, 5'h0, 5'h3, 5'h0, 16'h0), 1'b1);
    observe();
    chk("ptr_stall", 32'(DPI_AD_STALL_CYCLES), 32'(n_stall));
    send(mk(8'h62, 5'h0, 5'h0, 5'h7, 16'h0), mk(8'h61, 5'h7, 5'h0, 5'h0, 16'h0), 1'b1);
    observe();
    chk("src_stall", 32'(DPI_PEND_DEPTH), 32'(n_stall));
    @(posedge clk);
    pair <= 1'b1;
    cond <= 1'b1;
    send(mk(8'h62, 5'h0, 5'h0, 5'h3, 16'h0), mk(8'h64, 5'h0, 5'h4, 5'h0, 16'h0), 1'b1);
    observe();
    chk("no_false_stall", 32'h0, 32'(n_stall));
    @(posedge clk);
    pair <= 1'b0;
    // Count loaded before the body and decremented once per instruction leaving the address stage inside it
    rcnt <= 16'h0005;
    lrpt <= 1'b1;
    observe();
    chk("rpt_count", 32'h5, 32'(cnt));
    chk("fetch_hold", 32'h1, 32'(hold));
    send(mk(8'h60, 5'h0, 5'h0, 5'h0, 16'h0), '0, 1'b0);
    observe();
    chk("rpt_dec", 32'h4, 32'(cnt));
    @(posedge clk);
    lrpt <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("fetch_free", 32'h0, 32'(hold));
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    chk_zero();
    @(posedge clk);
    rstn <= 1'b1;
    send(mk(8'h10, 5'h0, 5'h0, 5'h0, 16'h0042), '0, 1'b0);
    observe();
    chk("write_after_reset", 32'h1, 32'(t_wv >= 0));
    chk("data_after_reset", 32'h0042, 32'(cwd));
    tally_and_finish();
  end
endmodule
